// file: hdl/cpux_pkg.sv
// Package with register map, opcodes, flag layout and state type of the core
package cpux_pkg;

   // Register file locations of the control registers
   localparam logic [7:0]  RF_IMR      = 8'hFB;
   localparam logic [7:0]  RF_FLAGS    = 8'hFC;
   localparam logic [7:0]  RF_RP       = 8'hFD;
   localparam logic [7:0]  IMR_RST     = 8'h00;
   localparam logic [7:0]  FLAGS_RST   = 8'h00;
   localparam logic [7:0]  RP_RST      = 8'h00;

   // Word indices on the bus; byte address is four times the index
   localparam logic [9:0]  IDX_INSTR   = 10'h100;
   localparam logic [9:0]  IDX_STAT    = 10'h101;
   localparam logic [9:0]  IDX_PC      = 10'h102;
   localparam logic [9:0]  IDX_SP      = 10'h103;
   localparam logic [9:0]  IDX_PMEM    = 10'h104;

   // Flag bit positions inside the flag register, and the enable bit of the IMR
   localparam int          FL_C        = 7;
   localparam int          FL_Z        = 6;
   localparam int          FL_S        = 5;
   localparam int          FL_V        = 4;
   localparam int          FL_D        = 3;
   localparam int          FL_H        = 2;
   localparam int          IMR_EN      = 7;

   // Opcode groups and single opcodes
   localparam logic [3:0]  HI_ADD      = 4'h0;
   localparam logic [3:0]  HI_ADC      = 4'h1;
   localparam logic [3:0]  HI_AND      = 4'h5;
   localparam logic [3:0]  HI_CP       = 4'hA;
   localparam logic [3:0]  LO_LOOP     = 4'hA;
   localparam logic [3:0]  LO_RR       = 4'h2;
   localparam logic [3:0]  LO_RIR      = 4'h3;
   localparam logic [3:0]  LO_GG       = 4'h4;
   localparam logic [3:0]  LO_GIG      = 4'h5;
   localparam logic [3:0]  LO_GIM      = 4'h6;
   localparam logic [3:0]  LO_IGIM     = 4'h7;
   localparam logic [3:0]  WR_PREFIX   = 4'hE;
   localparam logic [7:0]  OP_DEC_R    = 8'h00;
   localparam logic [7:0]  OP_DEC_IR   = 8'h01;
   localparam logic [7:0]  OP_COUNT_DOWN_WORD_RR  = 8'h80;
   localparam logic [7:0]  OP_COUNT_DOWN_WORD_IR  = 8'h81;
   localparam logic [7:0]  OP_CALL_DA  = 8'hD6;
   localparam logic [7:0]  OP_CALL_IRR = 8'hD4;
   localparam logic [7:0]  OP_LDC      = 8'hC2;
   localparam logic [7:0]  OP_PROGRAM_MEMORY_LOAD_STEP     = 8'hC3;
   localparam logic [7:0]  OP_INT_OFF  = 8'h8F;
   localparam logic [7:0]  OP_INT_ON   = 8'h9F;
   localparam logic [7:0]  OP_RETI     = 8'hBF;

   localparam logic [15:0] LEN1        = 16'h0001;
   localparam logic [15:0] LEN2        = 16'h0002;
   localparam logic [15:0] LEN3        = 16'h0003;
   localparam logic [15:0] STACK_STEP  = 16'h0002;
   localparam logic [15:0] RETI_STEP   = 16'h0003;
   localparam logic [7:0]  BYTE_NEG    = 8'h80;
   localparam logic [15:0] WORD_NEG    = 16'h8000;
   localparam logic [1:0]  RESP_OKAY   = 2'b00;
   localparam logic [1:0]  RESP_SLVERR = 2'b10;

   typedef struct packed {
      logic [255:0][7:0] rf;
      logic [255:0][7:0] pm;
      logic [15:0]       pc;
      logic [15:0]       sp;
      logic              aw_hold;
      logic [9:0]        aw_idx;
      logic              w_hold;
      logic [31:0]       w_data;
      logic [3:0]        w_strb;
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
      logic              bad_op;
      logic [7:0]        last_op;
   } cpux_state_t;

endpackage : cpux_pkg

// file: hdl/cpux_core.sv
// Instruction execute core with its register file behind an AXI4-Lite slave
`timescale 1ns/100ps
module cpux_core
   import cpux_pkg::*;
#(
   parameter int AW = 12
) (
   input  wire logic          clk,
   input  wire logic          srst,
   input  wire logic [AW-1:0] s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   input  wire logic [AW-1:0] s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready
);

   cpux_state_t q;
   cpux_state_t d;

   // Working register: upper nibble from the bank pointer
   function automatic logic [7:0] cpux_wreg(input logic [7:0] rp,
                                            input logic [3:0] n);
      cpux_wreg = {rp[7:4], n};
   endfunction : cpux_wreg

   // Register operand: prefix E selects a working register
   function automatic logic [7:0] cpux_reg(input logic [7:0] rp,
                                           input logic [7:0] b);
      cpux_reg = (b[7:4] == WR_PREFIX) ? {rp[7:4], b[3:0]} : b;
   endfunction : cpux_reg

   // Adder shared by add, add with carry and compare: {V, H, C, sum}
   function automatic logic [10:0] cpux_add(input logic [7:0] a,
                                            input logic [7:0] b,
                                            input logic       ci);
      logic [8:0] s;
      logic [4:0] h;
      s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
      h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
      cpux_add = {(a[7] == b[7]) && (s[7] != a[7]), h[4], s[8], s[7:0]};
   endfunction : cpux_add

   // Bus read decode
   function automatic logic [32:0] cpux_read(input cpux_state_t s,
                                             input logic [9:0]  idx);
      cpux_read = {1'b0, 32'h0000_0000};
      if (idx[9:8] == 2'b00) begin
         cpux_read = {1'b0, 24'h00_0000, s.rf[idx[7:0]]};
      end else begin
         case (idx)
            IDX_INSTR: cpux_read = {1'b0, 32'h0000_0000};
            IDX_STAT:  cpux_read = {1'b0, 23'h00_0000, s.bad_op, s.last_op};
            IDX_PC:    cpux_read = {1'b0, 16'h0000, s.pc};
            IDX_SP:    cpux_read = {1'b0, 16'h0000, s.sp};
            IDX_PMEM:  cpux_read = {1'b0, 32'h0000_0000};
            default:   cpux_read = {1'b1, 32'h0000_0000};
         endcase
      end
   endfunction : cpux_read

   always_comb begin
      logic [7:0]  op;
      logic [7:0]  b1;
      logic [7:0]  b2;
      logic [3:0]  hi;
      logic [3:0]  lo;
      logic [7:0]  rp;
      logic [7:0]  fl;
      logic [7:0]  da;
      logic [7:0]  dv;
      logic [7:0]  sv;
      logic [7:0]  pa;
      logic [7:0]  r8;
      logic [10:0] ar;
      logic [15:0] w16;
      logic [15:0] pcn;
      logic [15:0] sp2;
      logic [32:0] rd;
      logic        alu;
      op  = q.w_data[7:0];
      b1  = q.w_data[15:8];
      b2  = q.w_data[23:16];
      hi  = op[7:4];
      lo  = op[3:0];
      rp  = q.rf[RF_RP];
      fl  = q.rf[RF_FLAGS];
      da  = 8'h00;
      dv  = 8'h00;
      sv  = 8'h00;
      pa  = 8'h00;
      r8  = 8'h00;
      ar  = 11'h000;
      w16 = 16'h0000;
      pcn = q.pc;
      sp2 = q.sp;
      rd  = {1'b0, 32'h0000_0000};
      alu = (hi == HI_ADD || hi == HI_ADC || hi == HI_AND || hi == HI_CP)
            && lo >= LO_RR && lo <= LO_IGIM;
      d   = q;

      // Address and data are taken independently, in either order
      if (q.awready && s_axi_awvalid) begin
         d.aw_hold = 1'b1;
         d.aw_idx  = s_axi_awaddr[11:2];
      end
      if (q.wready && s_axi_wvalid) begin
         d.w_hold = 1'b1;
         d.w_data = s_axi_wdata;
         d.w_strb = s_axi_wstrb;
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end

      // Commit once both halves are held and the last answer has gone
      if (q.aw_hold && q.w_hold && !q.bvalid) begin
         d.aw_hold = 1'b0;
         d.w_hold  = 1'b0;
         d.bvalid  = 1'b1;
         d.bresp   = RESP_OKAY;
         if (q.aw_idx[9:8] == 2'b00) begin
            if (q.w_strb[0]) begin
               d.rf[q.aw_idx[7:0]] = q.w_data[7:0];
            end
         end else begin
            case (q.aw_idx)
               IDX_STAT: d.bad_op = 1'b0;
               IDX_PC: begin
                  if (q.w_strb[0]) d.pc[7:0]  = q.w_data[7:0];
                  if (q.w_strb[1]) d.pc[15:8] = q.w_data[15:8];
               end
               IDX_SP: begin
                  if (q.w_strb[0]) d.sp[7:0]  = q.w_data[7:0];
                  if (q.w_strb[1]) d.sp[15:8] = q.w_data[15:8];
               end
               IDX_PMEM: begin
                  if (q.w_strb[1:0] == 2'b11) d.pm[b1] = op;
               end
               IDX_INSTR: begin
                  // Whole instruction runs in this one cycle
                  d.last_op = op;
                  if (lo == LO_LOOP) begin
                     pcn = q.pc + LEN2;
                     r8  = q.rf[cpux_wreg(rp, hi)] - 8'h01;
                     d.rf[cpux_wreg(rp, hi)] = r8;
                     d.pc = (r8 != 8'h00)
                            ? pcn + {{8{b1[7]}}, b1} : pcn;
                  end else if (alu) begin
                     pcn = q.pc + ((lo <= LO_RIR) ? LEN2 : LEN3);
                     case (lo)
                        LO_RR: begin
                           da = cpux_wreg(rp, b1[7:4]);
                           sv = q.rf[cpux_wreg(rp, b1[3:0])];
                        end
                        LO_RIR: begin
                           da = cpux_wreg(rp, b1[7:4]);
                           sv = q.rf[q.rf[cpux_wreg(rp, b1[3:0])]];
                        end
                        LO_GG: begin
                           da = cpux_reg(rp, b2);
                           sv = q.rf[cpux_reg(rp, b1)];
                        end
                        LO_GIG: begin
                           da = cpux_reg(rp, b2);
                           sv = q.rf[q.rf[cpux_reg(rp, b1)]];
                        end
                        LO_GIM: begin
                           da = cpux_reg(rp, b1);
                           sv = b2;
                        end
                        default: begin
                           da = q.rf[cpux_reg(rp, b1)];
                           sv = b2;
                        end
                     endcase
                     dv = q.rf[da];
                     d.pc = pcn;
                     case (hi)
                        HI_AND: begin
                           r8 = dv & sv;
                           d.rf[da] = r8;
                           fl[FL_Z] = (r8 == 8'h00);
                           fl[FL_S] = r8[7];
                           fl[FL_V] = 1'b0;
                        end
                        HI_CP: begin
                           // Subtract as add of the complement, carry is borrow
                           ar = cpux_add(dv, ~sv, 1'b1);
                           fl[FL_C] = ~ar[8];
                           fl[FL_Z] = (ar[7:0] == 8'h00);
                           fl[FL_S] = ar[7];
                           fl[FL_V] = ar[10];
                        end
                        default: begin
                           ar = cpux_add(dv, sv,
                                         (hi == HI_ADC) && fl[FL_C]);
                           d.rf[da] = ar[7:0];
                           fl[FL_C] = ar[8];
                           fl[FL_Z] = (ar[7:0] == 8'h00);
                           fl[FL_S] = ar[7];
                           fl[FL_V] = ar[10];
                           fl[FL_H] = ar[9];
                           fl[FL_D] = 1'b0;
                        end
                     endcase
                     // Flag update wins if the destination was the flag byte
                     d.rf[RF_FLAGS] = fl;
                  end else begin
                     case (op)
                        OP_DEC_R, OP_DEC_IR: begin
                           da = (op == OP_DEC_R) ? cpux_reg(rp, b1)
                                                 : q.rf[cpux_reg(rp, b1)];
                           dv = q.rf[da];
                           r8 = dv - 8'h01;
                           d.rf[da] = r8;
                           fl[FL_Z] = (r8 == 8'h00);
                           fl[FL_S] = r8[7];
                           fl[FL_V] = (dv == BYTE_NEG);
                           d.rf[RF_FLAGS] = fl;
                           d.pc = q.pc + LEN2;
                        end
                        OP_COUNT_DOWN_WORD_RR, OP_COUNT_DOWN_WORD_IR: begin
                           pa = (op == OP_COUNT_DOWN_WORD_RR) ? cpux_reg(rp, b1)
                                                   : q.rf[cpux_reg(rp, b1)];
                           pa[0] = 1'b0;
                           w16 = {q.rf[pa], q.rf[pa | 8'h01]};
                           fl[FL_V] = (w16 == WORD_NEG);
                           w16 = w16 - 16'h0001;
                           d.rf[pa] = w16[15:8];
                           d.rf[pa | 8'h01] = w16[7:0];
                           fl[FL_Z] = (w16 == 16'h0000);
                           fl[FL_S] = w16[15];
                           d.rf[RF_FLAGS] = fl;
                           d.pc = q.pc + LEN2;
                        end
                        OP_CALL_DA, OP_CALL_IRR: begin
                           pcn = q.pc + ((op == OP_CALL_DA) ? LEN3 : LEN2);
                           pa  = cpux_reg(rp, b1);
                           pa[0] = 1'b0;
                           sp2 = q.sp - STACK_STEP;
                           d.sp = sp2;
                           d.rf[sp2[7:0]] = pcn[15:8];
                           d.rf[8'(sp2[7:0] + 8'h01)] = pcn[7:0];
                           d.pc = (op == OP_CALL_DA) ? {b1, b2}
                                  : {q.rf[pa], q.rf[pa | 8'h01]};
                        end
                        OP_LDC, OP_PROGRAM_MEMORY_LOAD_STEP: begin
                           // Only a working pair may point into program memory
                           pa = cpux_wreg(rp, {b1[3:1], 1'b0});
                           w16 = {q.rf[pa], q.rf[pa | 8'h01]};
                           da = cpux_wreg(rp, b1[7:4]);
                           if (op == OP_LDC) begin
                              d.rf[da] = q.pm[w16[7:0]];
                           end else begin
                              d.rf[q.rf[da]] = q.pm[w16[7:0]];
                              d.rf[da] = q.rf[da] + 8'h01;
                              w16 = w16 + 16'h0001;
                              d.rf[pa] = w16[15:8];
                              d.rf[pa | 8'h01] = w16[7:0];
                           end
                           d.pc = q.pc + LEN2;
                        end
                        OP_INT_OFF: begin
                           d.rf[RF_IMR][IMR_EN] = 1'b0;
                           d.pc = q.pc + LEN1;
                        end
                        OP_INT_ON: begin
                           d.rf[RF_IMR][IMR_EN] = 1'b1;
                           d.pc = q.pc + LEN1;
                        end
                        OP_RETI: begin
                           d.rf[RF_FLAGS] = q.rf[q.sp[7:0]];
                           d.pc = {q.rf[8'(q.sp[7:0] + 8'h01)],
                                   q.rf[8'(q.sp[7:0] + 8'h02)]};
                           d.sp = q.sp + RETI_STEP;
                           d.rf[RF_IMR][IMR_EN] = 1'b1;
                        end
                        default: begin
                           // Opcodes outside this core are flagged, not run
                           d.bad_op = 1'b1;
                        end
                     endcase
                  end
               end
               default: d.bresp = RESP_SLVERR;
            endcase
         end
      end

      // Read channel: one outstanding read, answer one cycle after address
      if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      if (q.arready && s_axi_arvalid) begin
         rd       = cpux_read(q, s_axi_araddr[11:2]);
         d.rvalid = 1'b1;
         d.rdata  = rd[31:0];
         d.rresp  = rd[32] ? RESP_SLVERR : RESP_OKAY;
      end
      d.awready = !d.aw_hold;
      d.wready  = !d.w_hold;
      d.arready = !d.rvalid;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         q <= '0;
         q.rf[RF_IMR]   <= IMR_RST;
         q.rf[RF_FLAGS] <= FLAGS_RST;
         q.rf[RF_RP]    <= RP_RST;
      end else begin
         q <= d;
      end
   end

   assign s_axi_awready = q.awready;
   assign s_axi_wready  = q.wready;
   assign s_axi_bvalid  = q.bvalid;
   assign s_axi_bresp   = q.bresp;
   assign s_axi_arready = q.arready;
   assign s_axi_rvalid  = q.rvalid;
   assign s_axi_rdata   = q.rdata;
   assign s_axi_rresp   = q.rresp;

endmodule : cpux_core

// file: sim/cpux_core_assertions.sv
// Register port timing checks for the execute core
`timescale 1ns/100ps
module cpux_core_assertions
   import cpux_pkg::*;
#(
   parameter int AW = 12
) (
   input wire logic          clk,
   input wire logic          srst,
   input wire logic [AW-1:0] s_axi_awaddr,
   input wire logic          s_axi_awvalid,
   input wire logic          s_axi_awready,
   input wire logic          s_axi_wvalid,
   input wire logic          s_axi_wready,
   input wire logic [1:0]    s_axi_bresp,
   input wire logic          s_axi_bvalid,
   input wire logic          s_axi_bready,
   input wire logic [AW-1:0] s_axi_araddr,
   input wire logic          s_axi_arvalid,
   input wire logic          s_axi_arready,
   input wire logic [31:0]   s_axi_rdata,
   input wire logic [1:0]    s_axi_rresp,
   input wire logic          s_axi_rvalid,
   input wire logic          s_axi_rready
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // Both halves taken while no earlier answer is still waiting
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && !s_axi_bvalid;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   chk_write_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   chk_write_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped early");
   chk_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
      else $error("read answer late");
   chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped early");
   chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while answer pending");
   chk_bad_read: assert property (s_rd_take ##0
      (s_axi_araddr[AW-1:2] > IDX_PMEM) |=> s_axi_rresp == RESP_SLVERR
      && s_axi_rdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   chk_good_read: assert property (s_rd_take ##0
      (s_axi_araddr[AW-1:2] <= IDX_PMEM) |=> s_axi_rresp == RESP_OKAY)
      else $error("mapped read refused");
   chk_byte_read: assert property (s_rd_take ##0
      (s_axi_araddr[AW-1:2] < 10'h100) |=> s_axi_rdata[31:8] == 24'h0)
      else $error("byte register read has upper bits");
   chk_bad_write: assert property (s_wr_take ##0
      (s_axi_awaddr[AW-1:2] > IDX_PMEM) |-> ##2 s_axi_bresp == RESP_SLVERR)
      else $error("unmapped write not refused");
   // Bus re-opens within three edges so back-to-back traffic keeps flowing
   chk_ready_back: assert property (s_axi_bvalid && s_axi_bready
      |=> ##[1:2] s_axi_awready)
      else $error("write address channel stays closed");
endmodule : cpux_core_assertions

bind cpux_core cpux_core_assertions #(.AW(AW)) cpux_core_assertions_i (
   .clk(clk), .srst(srst), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// file: sim/cpux_core_tb.sv
// Self-checking bench for the execute core through its register port
`timescale 1ns/100ps
module cpux_core_tb
   import cpux_pkg::*;
;
   typedef struct packed {
      logic [23:0] ins;
      logic [7:0]  a;
      logic [7:0]  b;
      logic [7:0]  fin;
      logic [7:0]  ea;
      logic [7:0]  ef;
   } cpux_row_t;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic [11:0] awaddr = 12'h000;
   logic        awvalid = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0]  wstrb = 4'h0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic [11:0] araddr = 12'h000;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   int          miscompares = 0;
   int          n_compared = 0;
   // Operands sit at 0x10 (dst) and 0x11 (src)
   cpux_row_t   rows [17] = '{
      '{24'h10_1104, 8'h7F, 8'h01, 8'h08, 8'h80, 8'h34},
      '{24'h10_1104, 8'hFF, 8'h01, 8'h00, 8'h00, 8'hC4},
      '{24'h10_1114, 8'h10, 8'h20, 8'h80, 8'h31, 8'h00},
      '{24'h10_1114, 8'h0F, 8'h00, 8'h88, 8'h10, 8'h04},
      '{24'h10_1154, 8'hF0, 8'h8F, 8'h9C, 8'h80, 8'hAC},
      '{24'h10_1154, 8'h0F, 8'hF0, 8'h00, 8'h00, 8'h40},
      '{24'h10_11A4, 8'h10, 8'h20, 8'h0C, 8'h10, 8'hAC},
      '{24'h10_11A4, 8'h80, 8'h01, 8'h00, 8'h80, 8'h10},
      '{24'h00_1000, 8'h80, 8'h00, 8'h8C, 8'h7F, 8'h9C},
      '{24'h00_1101, 8'h00, 8'h10, 8'h00, 8'hFF, 8'h20},
      '{24'h00_1080, 8'h10, 8'h00, 8'h80, 8'h0F, 8'h80},
      '{24'h00_1181, 8'h10, 8'h10, 8'h00, 8'h10, 8'h00},
      '{24'h08_E006, 8'h38, 8'h00, 8'h00, 8'h40, 8'h04},
      '{24'h10_1115, 8'h40, 8'h10, 8'h80, 8'h81, 8'h30},
      '{24'h0F_1157, 8'h3C, 8'h10, 8'h14, 8'h0C, 8'h04},
      '{24'h00_01A2, 8'h05, 8'h05, 8'h0C, 8'h05, 8'h4C},
      '{24'h00_0103, 8'h88, 8'h10, 8'h08, 8'h10, 8'h94}
   };

   cpux_core #(.AW(12)) cpux_core_i (
      .clk(clk), .srst(srst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready)
   );

   always #50 clk = ~clk;

   task automatic conclude;
      if (miscompares == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : conclude

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Bounded waits: a stuck slave shows up as a missing answer
   task automatic wr(input logic [9:0] i, input logic [31:0] d,
                     input logic [3:0] s = 4'hF,
                     input logic [1:0] er = RESP_OKAY,
                     input int slow = 0);
      int n;
      n = 0;
      @(posedge clk);
      awaddr <= {i, 2'b00};
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      wvalid <= 1'b1;
      bready <= (slow == 0);
      do begin
         @(posedge clk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (n == slow) bready <= 1'b1;
      end while (!(bvalid === 1'b1 && bready) && n < 40);
      bready <= 1'b0;
      chk("write answer", {29'h0, 1'b1, er}, {29'h0, bvalid, bresp});
   endtask : wr

   // A nonzero slow keeps the answer channel stalled for that many edges
   task automatic rd(input logic [9:0] i, input logic [31:0] e,
                     input logic [1:0] er = RESP_OKAY,
                     input int slow = 0);
      int n;
      n = 0;
      @(posedge clk);
      araddr <= {i, 2'b00};
      arvalid <= 1'b1;
      rready <= (slow == 0);
      do begin
         @(posedge clk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
         if (n == slow) rready <= 1'b1;
      end while (!(rvalid === 1'b1 && rready) && n < 40);
      rready <= 1'b0;
      chk("read answer", {29'h0, 1'b1, er}, {29'h0, rvalid, rresp});
      chk("read data", e, rdata);
   endtask : rd

   task automatic wb(input logic [7:0] r, input logic [7:0] d);
      wr({2'b00, r}, {24'h0, d});
   endtask : wb

   task automatic rb(input logic [7:0] r, input logic [7:0] e);
      rd({2'b00, r}, {24'h0, e});
   endtask : rb

   task automatic ex(input logic [23:0] ins);
      wr(IDX_INSTR, {8'h00, ins});
   endtask : ex

   initial begin
      repeat (6000) @(posedge clk);
      miscompares++;
      conclude();
   end

   initial begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      wb(RF_RP, 8'h10);
      foreach (rows[k]) begin
         wb(8'h10, rows[k].a);
         wb(8'h11, rows[k].b);
         wb(RF_FLAGS, rows[k].fin);
         ex(rows[k].ins);
         rb(8'h10, rows[k].ea);
         rb(RF_FLAGS, rows[k].ef);
      end
      wb(RF_RP, 8'h00);
      rd(10'h200, 32'h0000_0000, RESP_SLVERR);
      wr(10'h200, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
      wr(IDX_SP, 32'h0000_0080);
      wr(IDX_PC, 32'h0000_0010);
      wb(8'h20, 8'h12);
      wb(8'h21, 8'h34);
      wb(RF_FLAGS, 8'h5C);
      ex(24'h00_20D4);
      rd(IDX_PC, 32'h0000_1234);
      rd(IDX_SP, 32'h0000_007E, RESP_OKAY, 3);
      rb(8'h7E, 8'h00);
      rb(8'h7F, 8'h12);
      ex(24'h78_56D6);
      rd(IDX_PC, 32'h0000_5678);
      rb(8'h7D, 8'h37);
      wb(8'h03, 8'h02);
      wr(IDX_PC, 32'h0000_0040, 4'hF, RESP_OKAY, 3);
      ex(24'h00_FE3A);
      rd(IDX_PC, 32'h0000_0040);
      rb(8'h03, 8'h01);
      ex(24'h00_FE3A);
      rd(IDX_PC, 32'h0000_0042);
      rb(8'h03, 8'h00);
      ex(24'h00_009F);
      rb(RF_IMR, 8'h80);
      ex(24'h00_008F);
      rb(RF_IMR, 8'h00);
      rb(RF_FLAGS, 8'h5C);
      wr(IDX_SP, 32'h0000_0070);
      wb(8'h70, 8'hA4);
      wb(8'h71, 8'h12);
      wb(8'h72, 8'h34);
      ex(24'h00_00BF);
      rb(RF_FLAGS, 8'hA4);
      rd(IDX_PC, 32'h0000_1234);
      rd(IDX_SP, 32'h0000_0073);
      rb(RF_IMR, 8'h80);
      wr(IDX_PMEM, 32'h0000_559A, 4'h3);
      wb(8'h06, 8'h00);
      wb(8'h07, 8'h55);
      ex(24'h00_46C2);
      rb(8'h04, 8'h9A);
      wb(8'h04, 8'h30);
      ex(24'h00_46C3);
      rb(8'h30, 8'h9A);
      rb(8'h04, 8'h31);
      rb(8'h07, 8'h56);
      wb(RF_RP, 8'h20);
      @(posedge clk);
      srst <= 1'b1;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      rb(RF_IMR, IMR_RST);
      rb(RF_FLAGS, FLAGS_RST);
      rb(RF_RP, RP_RST);
      conclude();
   end
endmodule : cpux_core_tb
